// File: hw/tbu_pkg.sv
// tbu_pkg: register indices, field positions, modes and state carriers of the timer b unit
package tbu_pkg;
	// register indices; byte address is four times the index
	localparam logic [3:0] TBU_IDX_CTRL_A = 4'h0;
	localparam logic [3:0] TBU_IDX_CTRL_B = 4'h1;
	localparam logic [3:0] TBU_IDX_EVENT_CONTROL = 4'h4;
	localparam logic [3:0] TBU_IDX_INTEN = 4'h5;
	localparam logic [3:0] TBU_IDX_FLAGS = 4'h6;
	localparam logic [3:0] TBU_IDX_STATUS = 4'h7;
	localparam logic [3:0] TBU_IDX_DBG = 4'h8;
	localparam logic [3:0] TBU_IDX_TEMP = 4'h9;
	localparam logic [3:0] TBU_IDX_CNT_L = 4'ha;
	localparam logic [3:0] TBU_IDX_CNT_H = 4'hb;
	localparam logic [3:0] TBU_IDX_COMPARE_CAPTURE_LOW_L = 4'hc;
	localparam logic [3:0] TBU_IDX_COMPARE_CAPTURE_LOW_H = 4'hd;
	// field positions
	localparam int TBU_B_ENABLE = 0;
	localparam int TBU_B_CLOCK_SOURCE_SELECT = 1;
	localparam int TBU_B_RFOLLOW = 4;
	localparam int TBU_B_SRUN = 6;
	localparam int TBU_B_MODE = 0;
	localparam int TBU_B_OE = 4;
	localparam int TBU_B_INIT = 5;
	localparam int TBU_B_IMM = 6;
	localparam int TBU_B_EIE = 0;
	localparam int TBU_B_EDGE = 4;
	localparam int TBU_B_FILT = 6;
	localparam int TBU_B_CAPTURE_INTERRUPT = 0;
	localparam int TBU_B_DEBUG_RUN = 0;
	// writable bits of each control byte
	localparam logic [7:0] TBU_MASK_CTRL_A = 8'h57;
	localparam logic [7:0] TBU_MASK_CTRL_B = 8'h77;
	localparam logic [7:0] TBU_MASK_EVENT_CONTROL = 8'h51;
	localparam logic [7:0] TBU_MASK_BIT0 = 8'h01;
	localparam int TBU_FILT_TAPS = 4;
	localparam logic [1:0] TBU_RESP_OKAY = 2'h0;
	localparam logic [1:0] TBU_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {TBU_M_PERIODIC, TBU_M_TIMEOUT, TBU_M_CAPTURE_INTERRUPT, TBU_M_FRQ,
		TBU_M_PW, TBU_M_FRQPW, TBU_M_SINGLE, TBU_M_PWM} tbu_mode_e;
	typedef enum logic [1:0] {TBU_CK_PER, TBU_CK_DIV2, TBU_CK_TCA, TBU_CK_RSVD} tbu_clk_e;
	typedef struct packed {logic [TBU_FILT_TAPS-1:0] smp; logic lvl;} tbu_filt_s;
	typedef struct packed {logic wr; logic rd; logic [3:0] widx; logic [3:0] ridx; logic [7:0] wdat;} tbu_bus_s;
	typedef struct packed {
		logic aw; logic w; logic wmap; logic lane; logic [3:0] widx; logic [7:0] wdat;
		logic bv; logic [1:0] br; logic rv; logic [7:0] rd; logic [1:0] rr;
	} tbu_axi_s;
	typedef struct packed {
		logic [7:0] ca; logic [7:0] cb; logic [7:0] ev; logic ie; logic flag; logic dbg;
		logic [7:0] temp; logic [15:0] cnt; logic [15:0] compare_capture_low; logic run; logic div;
		logic ssl; logic pend; logic [1:0] ph; logic evp; logic evo; logic wave;
	} tbu_reg_s;
	localparam tbu_reg_s TBU_REG_RST = '0;
	localparam tbu_axi_s TBU_AXI_RST = '0;
	localparam tbu_filt_s TBU_FILT_RST = '0;
	// indices that hold a register
	function automatic logic tbu_idx_ok(input logic [3:0] idx);
		tbu_idx_ok = (idx != 4'h2) && (idx != 4'h3) && (idx <= TBU_IDX_COMPARE_CAPTURE_LOW_H);
	endfunction : tbu_idx_ok
endpackage : tbu_pkg

// File: hw/tbu_filter.sv
// tbu_filter: four-sample noise canceler on the event input, always on the system clock
`timescale 1ns/10ps
module tbu_filter import tbu_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic enable_in,
	input wire logic event_in,
	output logic level_out
);
	tbu_filt_s r, n;
	// shift one sample per system clock; prescaler never reaches here
	always_comb begin
		n = r;
		n.smp = {r.smp[TBU_FILT_TAPS-2:0], event_in};
		if ((&n.smp) || !(|n.smp)) begin
			n.lvl = n.smp[0];
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			r <= TBU_FILT_RST;
		end else begin
			r <= n;
		end
	end
	// bypassed when off, so the four-cycle delay exists only with filtering
	assign level_out = enable_in ? r.lvl : event_in;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_high4;
		(enable_in && event_in) [*4];
	endsequence
	sequence s_low4;
		(enable_in && !event_in) [*4];
	endsequence
	a_filter_rise: assert property (s_high4 |=> level_out) else $error("filter missed stable high");
	a_filter_fall: assert property (s_low4 |=> !level_out) else $error("filter missed stable low");
	// a level change must be backed by four equal input samples, not just by the shift register
	a_filter_glitch: assert property (enable_in && $changed(r.lvl) |-> r.lvl == $past(event_in) &&
		r.lvl == $past(event_in, 2) && r.lvl == $past(event_in, 3) && r.lvl == $past(event_in, 4))
		else $error("filter passed unstable input");
endmodule : tbu_filter

// File: hw/tbu_axil.sv
// tbu_axil: axi4-lite slave turning bus traffic into byte register strobes
`timescale 1ns/10ps
module tbu_axil import tbu_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output tbu_bus_s bus_out,
	input wire logic [7:0] rd_data_in
);
	tbu_axi_s r, n;
	logic amap;
	// address and data are caught independently; the strobe fires once both are held
	always_comb begin
		n = r;
		bus_out = '0;
		s_axi_awready_out = !r.aw && !r.bv;
		s_axi_wready_out = !r.w && !r.bv;
		s_axi_arready_out = !r.rv;
		amap = (s_axi_araddr_in[ADDR_W-1:6] == '0) && tbu_idx_ok(s_axi_araddr_in[5:2]);
		bus_out.widx = r.widx;
		bus_out.wdat = r.wdat;
		bus_out.ridx = s_axi_araddr_in[5:2];
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			n.aw = 1'b1;
			n.widx = s_axi_awaddr_in[5:2];
			n.wmap = (s_axi_awaddr_in[ADDR_W-1:6] == '0) && tbu_idx_ok(s_axi_awaddr_in[5:2]);
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			n.w = 1'b1;
			n.wdat = s_axi_wdata_in[7:0];
			n.lane = s_axi_wstrb_in[0]; // only the low lane carries register bits
		end
		if (r.aw && r.w) begin
			n.aw = 1'b0;
			n.w = 1'b0;
			n.bv = 1'b1;
			n.br = r.wmap ? TBU_RESP_OKAY : TBU_RESP_SLVERR;
			bus_out.wr = r.wmap && r.lane;
		end
		if (r.bv && s_axi_bready_in) begin
			n.bv = 1'b0;
		end
		if (r.rv && s_axi_rready_in) begin
			n.rv = 1'b0;
		end
		// read data is latched at acceptance, so side effects happen exactly once
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			n.rv = 1'b1;
			bus_out.rd = amap;
			n.rd = amap ? rd_data_in : 8'h00;
			n.rr = amap ? TBU_RESP_OKAY : TBU_RESP_SLVERR;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			r <= TBU_AXI_RST;
		end else begin
			r <= n;
		end
	end
	assign s_axi_bresp_out = r.br;
	assign s_axi_bvalid_out = r.bv;
	assign s_axi_rdata_out = {24'h000000, r.rd};
	assign s_axi_rresp_out = r.rr;
	assign s_axi_rvalid_out = r.rv;
endmodule : tbu_axil

// File: hw/tbu_top.sv
// tbu_top: timer b unit with control registers, clocking, events, interrupt and sleep logic
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
// How it works
// - filter on: four matching event samples needed before the edge detector sees a level
// - filter on: exactly four extra system clocks from input change to effect
// - filter runs on the system clock regardless of counter clock choice
// - clock select two: counter advances on the companion timer clock tick
// - restart follow set: counter restarts with the companion counter
// - one strobe on event output each time the event condition occurs
// - single event input acts only when enabled, per edge select and mode
// - one capture interrupt source whose flag sets on the mode condition
// - interrupt request high while enable and flag are both one
// - power-down stops all; standby runs only with standby run set or the companion clock selected
// - standby run at bit six ignored when companion clock selected
// - clock select: zero peripheral, one half rate, two companion, three reserved
// - enable bit zero of first control register activates the timer
// - single shot: output rises at count start, or at event when immediate
// - output initial level bit gives the output level in every mode except single shot and pwm
// - output enable zero forces output low, one passes the mode value
// - count mode decode of eight modes, zero periodic to seven pwm
// - flag clears by writing one or reading capture in capture modes
// - all 16-bit registers share one staging byte for atomic access
module tbu_top import tbu_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic event_in,
	input wire logic tca_tick_in,
	input wire logic tca_restart_in,
	input wire logic sleep_standby_in,
	input wire logic sleep_powerdown_in,
	input wire logic debug_halt_in,
	output logic event_out,
	output logic irq_out,
	output logic wave_out,
	output logic running_out
);
	tbu_reg_s r, n;
	tbu_bus_s bus;
	tbu_mode_e mode;
	tbu_clk_e cks;
	logic [7:0] rd_data;
	logic evl, act, tick, ev_ok, rise, fall, strt, stp, trig, setf, clr, capm, pwm_hi;

	tbu_axil #(.ADDR_W(ADDR_W)) u_axil (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.bus_out(bus),
		.rd_data_in(rd_data)
	);

	tbu_filter u_filter (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.enable_in(r.ev[TBU_B_FILT]),
		.event_in(event_in),
		.level_out(evl)
	);

	// register read mux; high bytes come back from the staging byte
	always_comb begin
		unique case (bus.ridx)
			TBU_IDX_CTRL_A: rd_data = r.ca;
			TBU_IDX_CTRL_B: rd_data = r.cb;
			TBU_IDX_EVENT_CONTROL: rd_data = r.ev;
			TBU_IDX_INTEN: rd_data = {7'h00, r.ie};
			TBU_IDX_FLAGS: rd_data = {7'h00, r.flag};
			TBU_IDX_STATUS: rd_data = {7'h00, r.run};
			TBU_IDX_DBG: rd_data = {7'h00, r.dbg};
			TBU_IDX_CNT_L: rd_data = r.cnt[7:0];
			TBU_IDX_COMPARE_CAPTURE_LOW_L: rd_data = r.compare_capture_low[7:0];
			TBU_IDX_TEMP, TBU_IDX_CNT_H, TBU_IDX_COMPARE_CAPTURE_LOW_H: rd_data = r.temp;
			default: rd_data = 8'h00;
		endcase
	end

	// timer behaviour, then bus side effects, which override the counting path
	always_comb begin
		n = r;
		mode = tbu_mode_e'(r.cb[TBU_B_MODE +: 3]);
		cks = tbu_clk_e'(r.ca[TBU_B_CLOCK_SOURCE_SELECT +: 2]);
		// sleep gating; with the companion clock the standby run bit has no say
		act = r.ca[TBU_B_ENABLE] && !sleep_powerdown_in
			&& !(sleep_standby_in && !r.ca[TBU_B_SRUN] && (cks != TBU_CK_TCA))
			&& !(debug_halt_in && !r.dbg);
		n.div = act ? !r.div : r.div;
		unique case (cks)
			TBU_CK_PER: tick = act;
			TBU_CK_DIV2: tick = act && r.div;
			TBU_CK_TCA: tick = act && tca_tick_in;
			TBU_CK_RSVD: tick = 1'b0;
		endcase
		// edge detection on the filtered line; disabled timer sees no events
		n.evp = evl;
		ev_ok = act && r.ev[TBU_B_EIE];
		rise = ev_ok && evl && !r.evp;
		fall = ev_ok && !evl && r.evp;
		strt = r.ev[TBU_B_EDGE] ? fall : rise;
		stp = r.ev[TBU_B_EDGE] ? rise : fall;
		trig = r.ev[TBU_B_EDGE] ? (rise || fall) : rise;
		setf = 1'b0;
		capm = (mode == TBU_M_CAPTURE_INTERRUPT) || (mode == TBU_M_FRQ) || (mode == TBU_M_PW) || (mode == TBU_M_FRQPW);
		if (act) begin
			unique case (mode)
				TBU_M_PERIODIC: begin
					n.run = 1'b1;
					if (tick) begin
						if (r.cnt == r.compare_capture_low) begin
							n.cnt = 16'h0000;
							setf = 1'b1;
						end else begin
							n.cnt = r.cnt + 16'h0001;
						end
					end
				end
				TBU_M_TIMEOUT: begin
					if (strt) begin
						n.cnt = 16'h0000;
						n.run = 1'b1;
					end else if (stp) begin
						n.run = 1'b0;
					end else if (tick && r.run) begin
						setf = (r.cnt == r.compare_capture_low);
						n.cnt = r.cnt + 16'h0001; // wraps at max
					end
				end
				TBU_M_CAPTURE_INTERRUPT: begin
					n.run = 1'b1;
					if (tick) begin
						n.cnt = r.cnt + 16'h0001;
					end
					if (strt) begin
						n.compare_capture_low = r.cnt;
						setf = 1'b1;
					end
				end
				TBU_M_FRQ: begin
					n.run = 1'b1;
					if (strt) begin
						n.compare_capture_low = r.cnt;
						n.cnt = 16'h0000;
						setf = 1'b1;
					end else if (tick) begin
						n.cnt = r.cnt + 16'h0001;
					end
				end
				TBU_M_PW: begin
					n.run = 1'b1;
					if (strt) begin
						n.cnt = 16'h0000;
					end else if (stp) begin
						n.compare_capture_low = r.cnt;
						setf = 1'b1;
					end else if (tick) begin
						n.cnt = r.cnt + 16'h0001;
					end
				end
				TBU_M_FRQPW: begin
					// phase: idle, counting, captured, done until the flag goes
					if (strt && (r.ph == 2'd0)) begin
						n.cnt = 16'h0000;
						n.run = 1'b1;
						n.ph = 2'd1;
					end else if (stp && (r.ph == 2'd1)) begin
						n.compare_capture_low = r.cnt;
						n.ph = 2'd2;
					end else if (strt && (r.ph == 2'd2)) begin
						n.run = 1'b0;
						n.ph = 2'd3;
						setf = 1'b1;
					end else if ((r.ph == 2'd3) && !r.flag) begin
						n.ph = 2'd0;
					end
					if (tick && r.run && (n.ph != 2'd3)) begin
						n.cnt = r.cnt + 16'h0001;
					end
				end
				TBU_M_SINGLE: begin
					// events that land while counting are dropped
					if (r.pend) begin
						n.pend = 1'b0;
						n.run = 1'b1;
						n.cnt = 16'h0000;
						n.ssl = 1'b1;
					end else if (!r.run && trig) begin
						n.pend = 1'b1;
						n.ssl = r.cb[TBU_B_IMM] ? 1'b1 : r.ssl;
					end else if (r.run && tick) begin
						if (r.cnt == r.compare_capture_low) begin
							n.run = 1'b0;
							n.ssl = 1'b0;
							setf = 1'b1;
						end else begin
							n.cnt = r.cnt + 16'h0001;
						end
					end
				end
				TBU_M_PWM: begin
					n.run = 1'b1;
					if (tick) begin
						setf = (r.cnt[7:0] == r.compare_capture_low[15:8]);
						n.cnt = (r.cnt[7:0] == r.compare_capture_low[7:0]) ? 16'h0000 : {8'h00, r.cnt[7:0] + 8'h01};
					end
				end
			endcase
			if (r.ca[TBU_B_RFOLLOW] && tca_restart_in) begin
				n.cnt = 16'h0000;
			end
		end else if (!r.ca[TBU_B_ENABLE]) begin
			n.run = 1'b0;
			n.pend = 1'b0;
		end
		// read side effects: staging byte grabs the high half, capture read clears the flag
		clr = 1'b0;
		if (bus.rd) begin
			if (bus.ridx == TBU_IDX_CNT_L) begin
				n.temp = r.cnt[15:8];
			end
			if (bus.ridx == TBU_IDX_COMPARE_CAPTURE_LOW_L) begin
				n.temp = r.compare_capture_low[15:8];
			end
			if ((bus.ridx == TBU_IDX_COMPARE_CAPTURE_LOW_H) && capm) begin
				clr = 1'b1;
			end
		end
		if (bus.wr) begin
			unique case (bus.widx)
				TBU_IDX_CTRL_A: n.ca = bus.wdat & TBU_MASK_CTRL_A;
				TBU_IDX_CTRL_B: n.cb = bus.wdat & TBU_MASK_CTRL_B;
				TBU_IDX_EVENT_CONTROL: n.ev = bus.wdat & TBU_MASK_EVENT_CONTROL;
				TBU_IDX_INTEN: n.ie = bus.wdat[TBU_B_CAPTURE_INTERRUPT];
				TBU_IDX_FLAGS: clr = clr || bus.wdat[TBU_B_CAPTURE_INTERRUPT];
				TBU_IDX_DBG: n.dbg = bus.wdat[TBU_B_DEBUG_RUN];
				TBU_IDX_TEMP, TBU_IDX_CNT_L, TBU_IDX_COMPARE_CAPTURE_LOW_L: n.temp = bus.wdat;
				TBU_IDX_CNT_H: n.cnt = {bus.wdat, r.temp};
				TBU_IDX_COMPARE_CAPTURE_LOW_H: n.compare_capture_low = {bus.wdat, r.temp};
				default: n.temp = n.temp; // status is read only
			endcase
		end
		// a new event beats a clear in the same cycle
		n.flag = setf || (r.flag && !clr);
		n.evo = setf;
		pwm_hi = (r.compare_capture_low[7:0] != 8'h00) && (n.cnt[7:0] < r.compare_capture_low[15:8]);
		unique case (mode)
			TBU_M_SINGLE: n.wave = n.ssl;
			TBU_M_PWM: n.wave = pwm_hi;
			default: n.wave = r.cb[TBU_B_INIT];
		endcase
		n.wave = n.wave && r.cb[TBU_B_OE];
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			r <= TBU_REG_RST;
		end else begin
			r <= n;
		end
	end

	assign event_out = r.evo;
	assign irq_out = r.ie && r.flag;
	assign wave_out = r.wave;
	assign running_out = r.run;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_flag_pending;
		r.flag && r.ie && !clr && !(bus.wr && bus.widx == TBU_IDX_INTEN);
	endsequence
	property p_hold_when_off;
		!r.ca[TBU_B_ENABLE] && !bus.wr |=> $stable(r.cnt);
	endproperty
	a_irq_follows: assert property (s_flag_pending |=> irq_out) else $error("irq dropped while flag set");
	a_irq_off: assert property (!r.ie |-> !irq_out) else $error("irq without enable");
	a_off_hold: assert property (p_hold_when_off) else $error("counter moved while disabled");
	a_pd_stop: assert property (sleep_powerdown_in && !bus.wr |=> $stable(r.cnt)) else $error("count in power-down");
	a_out_forced: assert property (!r.cb[TBU_B_OE] |=> !wave_out) else $error("output not forced low");
	a_evout_flag: assert property (event_out |-> r.flag) else $error("event strobe without flag");
	a_period_wrap: assert property (act && mode == TBU_M_PERIODIC && tick && r.cnt == r.compare_capture_low && !bus.wr
		|=> r.cnt == 16'h0000 && r.flag && event_out) else $error("periodic wrap wrong");
	a_cap_clear: assert property (bus.rd && bus.ridx == TBU_IDX_COMPARE_CAPTURE_LOW_H && capm && !setf |=> !r.flag)
		else $error("capture read kept flag");
	a_tca_gate: assert property (act && cks == TBU_CK_TCA && !tca_tick_in |-> !tick)
		else $error("tick without companion clock");
	a_stage: assert property (bus.rd && bus.ridx == TBU_IDX_CNT_L && !bus.wr
		|=> r.temp == $past(r.cnt[15:8])) else $error("staging byte missed high half");
	// steps of the half-rate divider and of standby gating, reused below
	sequence s_half_tick;
		act && cks == TBU_CK_DIV2 && tick;
	endsequence
	sequence s_standby_held;
		sleep_standby_in && !r.ca[TBU_B_SRUN] && (cks != TBU_CK_TCA) && !bus.wr;
	endsequence
	a_flag_keep: assert property (r.flag && !clr |=> r.flag) else $error("flag lost without clear");
	a_set_wins: assert property (setf |=> r.flag && event_out) else $error("event did not set flag");
	a_rsvd_idle: assert property (cks == TBU_CK_RSVD |-> !tick) else $error("tick on reserved clock");
	a_half_rate: assert property (s_half_tick ##1 (act && cks == TBU_CK_DIV2) |-> !tick)
		else $error("half rate ticked twice");
	a_standby_stop: assert property (s_standby_held |=> $stable(r.cnt)) else $error("count in standby");
	a_follow_restart: assert property (act && r.ca[TBU_B_RFOLLOW] && tca_restart_in && !bus.wr
		|=> r.cnt == 16'h0000) else $error("companion restart not followed");
	a_single_imm: assert property (act && mode == TBU_M_SINGLE && r.cb[TBU_B_IMM] && r.cb[TBU_B_OE]
		&& !r.run && !r.pend && trig |=> wave_out) else $error("immediate output late");
	a_off_quiet: assert property (!r.ca[TBU_B_ENABLE] |=> !event_out && !running_out)
		else $error("disabled timer active");
endmodule : tbu_top

// File: test/tbu_partner.sv
// tbu_partner: companion timer model giving count ticks and restart pulses
`timescale 1ns/10ps
module tbu_partner #(
	parameter int TICK_DIV = 4
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic count_on_event_enable_in,
	input wire logic ev_tick_in,
	input wire logic restart_req_in,
	output logic tick_out,
	output logic restart_out
);
	int div_r;
	// prescaled tick every TICK_DIV clocks; a restart also restarts the prescaler
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || restart_req_in) begin
			div_r <= 0;
			tick_out <= 1'b0;
		end else begin
			div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
			// event ticks replace the prescaled ones only with count on event set
			tick_out <= count_on_event_enable_in ? ev_tick_in : (run_in && div_r == TICK_DIV - 1);
		end
		restart_out <= rst_n_in && restart_req_in;
	end
endmodule : tbu_partner

// File: test/test_timer_b_control_events.sv
// test_timer_b_control_events: self-checking bench for the timer b unit
`timescale 1ns/10ps
module test_timer_b_control_events import tbu_pkg::*; ;
	localparam logic [1:0] OK = TBU_RESP_OKAY;
	logic clk = 1'b0, rst_n = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0] ws = 4'h0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic ev = 1'b0, sb = 1'b0, pd = 1'b0, dh = 1'b0, prun = 1'b0, preq = 1'b0;
	logic awr, wr, bv, arr, rv, evo, irq, wave, run, tick, rs;
	logic [1:0] br, rr;
	int fail_count = 0;
	int checks = 0;
	// system clock, 10 ns period
	always #5 clk = ~clk;
	// companion timer model, the only source of ticks and restarts
	tbu_partner #(.TICK_DIV(4)) i_tca (.clk_sys_in(clk), .rst_n_in(rst_n), .run_in(prun),
		.count_on_event_enable_in(1'b0), .ev_tick_in(1'b0), .restart_req_in(preq),
		.tick_out(tick), .restart_out(rs));
	tbu_top i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .event_in(ev),
		.tca_tick_in(tick), .tca_restart_in(rs), .sleep_standby_in(sb), .sleep_powerdown_in(pd),
		.debug_halt_in(dh), .event_out(evo), .irq_out(irq), .wave_out(wave), .running_out(run));
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic hang;
		fail_count++;
		$display("mismatch at %0t: wait timed out", $time);
		tally_and_finish();
	endtask : hang
	// one byte write; bready stays up until the response is seen
	task automatic wr8(input logic [3:0] i, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awa <= {2'b00, i, 2'b00};
		wd <= {24'h0, d};
		ws <= 4'h1;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) begin
				bry <= 1'b0;
				chk(br, er);
				return;
			end
		end
		hang();
	endtask : wr8
	task automatic rd8(input logic [3:0] i, output logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		ara <= {2'b00, i, 2'b00};
		arv <= 1'b1;
		rry <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv) begin
				rry <= 1'b0;
				d = rd[7:0];
				r = rr;
				return;
			end
		end
		hang();
	endtask : rd8
	task automatic rchk(input logic [3:0] i, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd8(i, d, r);
		chk({r, d}, {OK, e});
	endtask : rchk
	// cycles between two event strobes, 0 when fewer than two come
	task automatic per(output int p);
		int t0;
		p = 0;
		t0 = -1;
		for (int n = 0; n < 60 && p == 0; n++) begin
			@(posedge clk);
			#1;
			if (evo && t0 >= 0) p = n - t0;
			else if (evo) t0 = n;
		end
	endtask : per
	// edges from raising the event line to a strobe (or wave high); line held 12+ cycles
	task automatic lat(input logic w, output int l);
		l = 0;
		@(posedge clk);
		ev <= 1'b1;
		for (int n = 1; n < 20 && l == 0; n++) begin
			@(posedge clk);
			#1;
			if (w ? wave : evo) l = n;
		end
		repeat (12) @(posedge clk);
		ev <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : lat
	task automatic t_regs;
		logic [7:0] d;
		logic [1:0] r;
		logic [3:0] ix[8];
		ix = '{TBU_IDX_CTRL_A, TBU_IDX_CTRL_B, TBU_IDX_EVENT_CONTROL, TBU_IDX_INTEN, TBU_IDX_FLAGS,
			TBU_IDX_STATUS, TBU_IDX_DBG, TBU_IDX_TEMP};
		foreach (ix[k]) rchk(ix[k], 8'h00);
		wr8(TBU_IDX_CTRL_B, 8'hff, OK);
		rchk(TBU_IDX_CTRL_B, 8'h77);
		wr8(TBU_IDX_EVENT_CONTROL, 8'hff, OK);
		rchk(TBU_IDX_EVENT_CONTROL, 8'h51);
		wr8(TBU_IDX_CTRL_A, 8'hff, OK);
		rchk(TBU_IDX_CTRL_A, 8'h57);
		wr8(TBU_IDX_CTRL_A, 8'h00, OK);
		wr8(TBU_IDX_CTRL_B, 8'h00, OK);
		wr8(TBU_IDX_EVENT_CONTROL, 8'h00, OK);
		wr8(TBU_IDX_STATUS, 8'hff, OK);
		rchk(TBU_IDX_STATUS, 8'h00);
		rd8(4'h2, d, r);
		chk({r, d}, {TBU_RESP_SLVERR, 8'h00});
		wr8(4'h3, 8'h55, TBU_RESP_SLVERR);
		$display("test regs done");
	endtask : t_regs
	// periodic strobes at each clock choice, then the interrupt path
	task automatic t_per;
		int p;
		int ep[4];
		ep = '{3, 6, 12, 0};
		wr8(TBU_IDX_COMPARE_CAPTURE_LOW_L, 8'h02, OK);
		wr8(TBU_IDX_COMPARE_CAPTURE_LOW_H, 8'h00, OK);
		wr8(TBU_IDX_INTEN, 8'h01, OK);
		for (int c = 0; c < 4; c++) begin
			wr8(TBU_IDX_CTRL_A, {5'h0, c[1:0], 1'b1}, OK);
			per(p);
			chk(p, ep[c]);
		end
		chk(run, 1'b1);
		chk(irq, 1'b1);
		rchk(TBU_IDX_FLAGS, 8'h01);
		wr8(TBU_IDX_INTEN, 8'h00, OK);
		chk(irq, 1'b0);
		wr8(TBU_IDX_INTEN, 8'h01, OK);
		chk(irq, 1'b1);
		wr8(TBU_IDX_FLAGS, 8'h01, OK);
		chk(irq, 1'b0);
		rchk(TBU_IDX_FLAGS, 8'h00);
		$display("test periodic done");
	endtask : t_per
	// standby, power-down, debug halt and disable against the periodic strobe
	task automatic t_sleep;
		int p;
		int ep[6];
		logic [10:0] cf[6];
		cf = '{11'h401, 11'h441, 11'h241, 11'h405, 11'h101, 11'h000};
		ep = '{0, 3, 0, 12, 0, 0};
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			{sb, pd, dh} <= cf[k][10:8];
			wr8(TBU_IDX_CTRL_A, cf[k][7:0], OK);
			per(p);
			chk(p, ep[k]);
		end
		@(posedge clk);
		{sb, pd, dh} <= 3'b000;
		$display("test sleep done");
	endtask : t_sleep
	// capture on event: filter latency, glitch, enables, read clear
	task automatic t_cap;
		int u, f, l;
		logic [7:0] d;
		logic [1:0] r;
		wr8(TBU_IDX_CTRL_B, 8'h02, OK);
		wr8(TBU_IDX_CTRL_A, 8'h01, OK);
		wr8(TBU_IDX_EVENT_CONTROL, 8'h01, OK);
		lat(1'b0, u);
		wr8(TBU_IDX_EVENT_CONTROL, 8'h41, OK);
		lat(1'b0, f);
		chk(f - u, 4);
		rchk(TBU_IDX_FLAGS, 8'h01);
		rd8(TBU_IDX_COMPARE_CAPTURE_LOW_L, d, r);
		rd8(TBU_IDX_COMPARE_CAPTURE_LOW_H, d, r);
		rchk(TBU_IDX_FLAGS, 8'h00);
		wr8(TBU_IDX_CTRL_A, 8'h07, OK);
		lat(1'b0, l);
		chk(l, f);
		@(posedge clk);
		ev <= 1'b1;
		repeat (3) @(posedge clk);
		ev <= 1'b0;
		l = 0;
		repeat (20) @(posedge clk) l += int'(evo);
		chk(l, 0);
		wr8(TBU_IDX_EVENT_CONTROL, 8'h00, OK);
		lat(1'b0, l);
		chk(l, 0);
		wr8(TBU_IDX_EVENT_CONTROL, 8'h01, OK);
		wr8(TBU_IDX_CTRL_A, 8'h00, OK);
		lat(1'b0, l);
		chk(l, 0);
		chk(run, 1'b0);
		$display("test capture done");
	endtask : t_cap
	// output levels, single shot start, staging and restart follow
	task automatic t_out;
		int d0, d1;
		logic [8:0] ob[3];
		ob = '{9'h020, 9'h130, 9'h010};
		wr8(TBU_IDX_CTRL_A, 8'h07, OK);
		foreach (ob[k]) begin
			wr8(TBU_IDX_CTRL_B, ob[k][7:0], OK);
			repeat (3) @(posedge clk);
			chk(wave, ob[k][8]);
		end
		wr8(TBU_IDX_CTRL_A, 8'h00, OK);
		wr8(TBU_IDX_COMPARE_CAPTURE_LOW_L, 8'h05, OK);
		wr8(TBU_IDX_COMPARE_CAPTURE_LOW_H, 8'h00, OK);
		wr8(TBU_IDX_CTRL_B, 8'h16, OK);
		wr8(TBU_IDX_CTRL_A, 8'h01, OK);
		repeat (30) @(posedge clk);
		lat(1'b1, d0);
		wr8(TBU_IDX_CTRL_B, 8'h56, OK);
		lat(1'b1, d1);
		chk(d0 - d1, 1);
		wr8(TBU_IDX_CTRL_A, 8'h00, OK);
		wr8(TBU_IDX_CTRL_B, 8'h00, OK);
		wr8(TBU_IDX_CNT_L, 8'h34, OK);
		wr8(TBU_IDX_CNT_H, 8'h12, OK);
		rchk(TBU_IDX_CNT_L, 8'h34);
		rchk(TBU_IDX_TEMP, 8'h12);
		rchk(TBU_IDX_CNT_H, 8'h12);
		wr8(TBU_IDX_COMPARE_CAPTURE_LOW_L, 8'hff, OK);
		wr8(TBU_IDX_COMPARE_CAPTURE_LOW_H, 8'hff, OK);
		wr8(TBU_IDX_CTRL_A, 8'h15, OK);
		repeat (40) @(posedge clk);
		prun <= 1'b0;
		@(posedge clk);
		preq <= 1'b1;
		@(posedge clk);
		preq <= 1'b0;
		repeat (3) @(posedge clk);
		rchk(TBU_IDX_CNT_L, 8'h00);
		rchk(TBU_IDX_CNT_H, 8'h00);
		$display("test output done");
	endtask : t_out
	// reset for four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		prun <= 1'b1;
		t_regs();
		t_per();
		t_sleep();
		t_cap();
		t_out();
		tally_and_finish();
	end
endmodule : test_timer_b_control_events
